// file: src/stpm_top.sv
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
module stpm_top #(
   parameter int CNT_W    = 24,
   parameter int PRESCALE = stpm_pkg::PRESCALE_DEF
) (
   input  wire logic          i_clock,
   input  wire logic          i_rst,
   input  wire logic [7:0]    i_avs_address,
   input  wire logic          i_avs_read,
   input  wire logic          i_avs_write,
   input  wire logic [31:0]   i_avs_writedata,
   input  wire logic [3:0]    i_avs_byteenable,
   output logic      [31:0]   o_avs_readdata,
   output logic               o_avs_waitrequest,
   input  wire logic [2:0]    i_port_pin_in,
   output logic      [2:0]    o_port_pin_out,
   output logic      [2:0]    o_port_pin_oe,
   input  wire logic          i_serial_tx,
   input  wire logic          i_serial_clk_out,
   input  wire logic          i_serial_clk_oe,
   output logic               o_serial_rx,
   output logic               o_serial_clk_in,
   input  wire logic [2:0]    i_timer_pin_in,
   output logic      [2:0]    o_timer_pin_out,
   output logic      [2:0]    o_timer_pin_oe,
   output logic      [2:0]    o_timer_irq
);
   import stpm_pkg::*;

   // ****************************************
   // Parameter checks
   // ****************************************
   if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
      $error("CNT_W must lie between 2 and 32");
   end
   if (PRESCALE < 1 || PRESCALE > 65536) begin : g_bad_prescale
      $error("PRESCALE must lie between 1 and 65536");
   end

   // ****************************************
   // Register state
   // ****************************************
   logic [2:0]         port_control_reg_q;
   logic [2:0]         port_control_reg_d;
   logic [2:0]         port_direction_reg_q;
   logic [2:0]         port_direction_reg_d;
   logic [2:0]         port_data_q;
   logic [2:0]         port_data_d;
   logic [TC_WR_W-1:0] tmr_ctrl_q [3];
   logic [TC_WR_W-1:0] tmr_ctrl_d [3];
   logic [CNT_W-1:0]   tmr_cmp_q  [3];
   logic [CNT_W-1:0]   tmr_cmp_d  [3];
   logic [2:0]         done_clr;
   logic [CNT_W-1:0]   tmr_count  [3];
   logic [2:0]         tmr_done;
   logic [2:0]         tmr_pin_out;
   logic [31:0]        rdata_d;
   logic               wait_d;
   logic               take;
   logic [2:0]         irq_d;

   // ****************************************
   // Internal tick divider
   // ****************************************
   logic [15:0] div_q;
   logic [15:0] div_d;
   logic        tick;

   assign tick = (div_q == 16'(PRESCALE - 1));

   always_comb begin
      div_d = tick ? 16'h0000 : div_q + 16'h0001;
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         div_q <= 16'h0000;
      end else begin
         div_q <= div_d;
      end
   end

   // ****************************************
   // Avalon slave
   // ****************************************
   // One wait state per access keeps the read mux off the bus path
   assign take = (i_avs_read | i_avs_write) & ~o_avs_waitrequest;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   always_comb begin
      wait_d = 1'b1;
      if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
         wait_d = 1'b0;
      end
   end

   always_comb begin
      rdata_d = 32'h0000_0000;
      unique case (i_avs_address)
         OFS_PORT_CTRL: rdata_d[2:0] = port_control_reg_q;
         OFS_PORT_DIR:  rdata_d[2:0] = port_direction_reg_q;
         OFS_PORT_DATA: rdata_d[2:0] = i_port_pin_in;
         default: begin
            for (int t = 0; t < 3; t++) begin
               if (i_avs_address == OFS_TMR_CTRL + 8'(t) * OFS_TMR_STEP) begin
                  rdata_d[TC_WR_W-1:0] = tmr_ctrl_q[t];
                  rdata_d[TC_DONE]     = tmr_done[t];
                  rdata_d[TC_LEVEL]    = i_timer_pin_in[t];
               end
               if (i_avs_address == OFS_TMR_CMP + 8'(t) * OFS_TMR_STEP) begin
                  rdata_d[CNT_W-1:0] = tmr_cmp_q[t];
               end
               if (i_avs_address == OFS_TMR_CNT + 8'(t) * OFS_TMR_STEP) begin
                  rdata_d[CNT_W-1:0] = tmr_count[t];
               end
            end
         end
      endcase
   end

   // ****************************************
   // Register writes
   // ****************************************
   always_comb begin
      logic [31:0] m;
      m                    = 32'h0000_0000;
      port_control_reg_d   = port_control_reg_q;
      port_direction_reg_d = port_direction_reg_q;
      port_data_d          = port_data_q;
      done_clr             = 3'h0;
      for (int t = 0; t < 3; t++) begin
         tmr_ctrl_d[t] = tmr_ctrl_q[t];
         tmr_cmp_d[t]  = tmr_cmp_q[t];
      end
      if (take && i_avs_write) begin
         unique case (i_avs_address)
            OFS_PORT_CTRL: begin
               m                  = merge(32'(port_control_reg_q), i_avs_writedata, i_avs_byteenable);
               port_control_reg_d = m[2:0];
            end
            OFS_PORT_DIR: begin
               m                    = merge(32'(port_direction_reg_q), i_avs_writedata, i_avs_byteenable);
               port_direction_reg_d = m[2:0];
            end
            OFS_PORT_DATA: begin
               m           = merge(32'(port_data_q), i_avs_writedata, i_avs_byteenable);
               port_data_d = m[2:0];
            end
            default: begin
               for (int t = 0; t < 3; t++) begin
                  if (i_avs_address == OFS_TMR_CTRL + 8'(t) * OFS_TMR_STEP) begin
                     m             = merge(32'(tmr_ctrl_q[t]), i_avs_writedata, i_avs_byteenable);
                     tmr_ctrl_d[t] = m[TC_WR_W-1:0];
                     // Done is write-one-to-clear; a same-cycle expiry still wins
                     done_clr[t]   = i_avs_byteenable[1] & i_avs_writedata[TC_DONE];
                  end
                  if (i_avs_address == OFS_TMR_CMP + 8'(t) * OFS_TMR_STEP) begin
                     m            = merge(32'(tmr_cmp_q[t]), i_avs_writedata, i_avs_byteenable);
                     tmr_cmp_d[t] = m[CNT_W-1:0];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         port_control_reg_q   <= RST_PORT_CTRL;
         port_direction_reg_q <= RST_PORT_DIR;
         port_data_q          <= RST_PORT_DATA;
         o_avs_waitrequest    <= 1'b1;
         o_avs_readdata       <= 32'h0000_0000;
         for (int t = 0; t < 3; t++) begin
            tmr_ctrl_q[t] <= RST_TMR_CTRL;
            tmr_cmp_q[t]  <= '0;
         end
      end else begin
         port_control_reg_q   <= port_control_reg_d;
         port_direction_reg_q <= port_direction_reg_d;
         port_data_q          <= port_data_d;
         o_avs_waitrequest    <= wait_d;
         o_avs_readdata       <= rdata_d;
         for (int t = 0; t < 3; t++) begin
            tmr_ctrl_q[t] <= tmr_ctrl_d[t];
            tmr_cmp_q[t]  <= tmr_cmp_d[t];
         end
      end
   end

   // ****************************************
   // Serial port pins
   // ****************************************
   logic [2:0] ser_func_out;
   logic [2:0] ser_func_oe;
   stpm_pin_t  ser_drive [3];
   logic       serial_rx_d;
   logic       serial_clk_in_d;

   always_comb begin
      ser_func_out         = 3'h0;
      ser_func_oe          = 3'h0;
      ser_func_oe[PB_RX]   = 1'b0;
      ser_func_out[PB_TX]  = i_serial_tx;
      ser_func_oe[PB_TX]   = 1'b1;
      ser_func_out[PB_CLK] = i_serial_clk_out;
      ser_func_oe[PB_CLK]  = i_serial_clk_oe;
   end

   // Idle levels keep the serial unit quiet while its pins serve as GPIO
   always_comb begin
      serial_rx_d     = port_control_reg_q[PB_RX] ? i_port_pin_in[PB_RX] : 1'b1;
      serial_clk_in_d = port_control_reg_q[PB_CLK] ? i_port_pin_in[PB_CLK] : 1'b0;
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_serial_rx     <= 1'b1;
         o_serial_clk_in <= 1'b0;
      end else begin
         o_serial_rx     <= serial_rx_d;
         o_serial_clk_in <= serial_clk_in_d;
      end
   end

   // ****************************************
   // Timers and their pins
   // ****************************************
   stpm_pin_t tmr_drive [3];

   for (genvar g = 0; g < 3; g++) begin : g_ch
      stpm_mode_t mode;
      logic       func_oe;

      assign mode = stpm_mode_t'(tmr_ctrl_q[g][TC_MODE_HI:TC_MODE_LO]);
      assign func_oe = ~(mode == MODE_EVENT || mode == MODE_MEASURE);

      stpm_pin_cell u_ser_cell (
         .i_clock    (i_clock),
         .i_rst      (i_rst),
         .i_func_sel (port_control_reg_q[g]),
         .i_gp_dir   (port_direction_reg_q[g]),
         .i_gp_out   (port_data_q[g]),
         .i_func_out (ser_func_out[g]),
         .i_func_oe  (ser_func_oe[g]),
         .o_drive    (ser_drive[g])
      );

      stpm_timer #(
         .CNT_W (CNT_W)
      ) u_timer (
         .i_clock      (i_clock),
         .i_rst        (i_rst),
         .i_enable     (tmr_ctrl_q[g][TC_ENABLE] & tmr_ctrl_q[g][TC_FUNC]),
         .i_mode       (mode),
         .i_ext_sel    (tmr_ctrl_q[g][TC_EXT]),
         .i_tick       (tick),
         .i_pin        (i_timer_pin_in[g]),
         .i_compare    (tmr_cmp_q[g]),
         .i_clear_done (done_clr[g]),
         .o_count      (tmr_count[g]),
         .o_done       (tmr_done[g]),
         .o_pin_out    (tmr_pin_out[g])
      );

      stpm_pin_cell u_tmr_cell (
         .i_clock    (i_clock),
         .i_rst      (i_rst),
         .i_func_sel (tmr_ctrl_q[g][TC_FUNC]),
         .i_gp_dir   (tmr_ctrl_q[g][TC_GP_DIR]),
         .i_gp_out   (tmr_ctrl_q[g][TC_GP_OUT]),
         .i_func_out (tmr_pin_out[g]),
         .i_func_oe  (func_oe),
         .o_drive    (tmr_drive[g])
      );

      assign o_port_pin_out[g]  = ser_drive[g].out;
      assign o_port_pin_oe[g]   = ser_drive[g].oe;
      assign o_timer_pin_out[g] = tmr_drive[g].out;
      assign o_timer_pin_oe[g]  = tmr_drive[g].oe;
      assign irq_d[g]           = tmr_done[g] & tmr_ctrl_q[g][TC_IRQ_EN];
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_timer_irq <= 3'h0;
      end else begin
         o_timer_irq <= irq_d;
      end
   end

endmodule : stpm_top

// file: src/stpm_pkg.sv
//
// What this block does
// - All three serial pins reset to general-purpose I/O.
// - A serial pin in general-purpose mode takes direction from its direction bit.
// - Each pin's control bit picks serial function or general-purpose I/O.
// - Selected receive pin is an input feeding the serial receiver.
// - Selected transmit pin drives the serial unit's transmit data.
// - Selected serial clock pin is bidirectional, driving or taking the serial clock.
// - Timer pin is input in event or measurement mode, output otherwise.
// - Timer pins reset to general-purpose input; timer control may change that.
// - Three identical independent timers, each counting internal or external clock.
// - A timer flags the processor or drives its pin after a programmed count.
//
package stpm_pkg;

   // ****************************************
   // Register map, byte addresses
   // ****************************************
   localparam logic [7:0] OFS_PORT_CTRL = 8'h00;
   localparam logic [7:0] OFS_PORT_DIR  = 8'h04;
   localparam logic [7:0] OFS_PORT_DATA = 8'h08;
   localparam logic [7:0] OFS_TMR_CTRL  = 8'h10;
   localparam logic [7:0] OFS_TMR_CMP   = 8'h20;
   localparam logic [7:0] OFS_TMR_CNT   = 8'h30;
   localparam logic [7:0] OFS_TMR_STEP  = 8'h04;

   // ****************************************
   // Timer control and status fields
   // ****************************************
   localparam int TC_FUNC    = 0;
   localparam int TC_ENABLE  = 1;
   localparam int TC_MODE_LO = 2;
   localparam int TC_MODE_HI = 4;
   localparam int TC_EXT     = 5;
   localparam int TC_IRQ_EN  = 6;
   localparam int TC_GP_DIR  = 7;
   localparam int TC_GP_OUT  = 8;
   localparam int TC_DONE    = 9;
   localparam int TC_LEVEL   = 10;
   localparam int TC_WR_W    = 9;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [2:0]        RST_PORT_CTRL = 3'h0;
   localparam logic [2:0]        RST_PORT_DIR  = 3'h0;
   localparam logic [2:0]        RST_PORT_DATA = 3'h0;
   localparam logic [TC_WR_W-1:0] RST_TMR_CTRL = 9'h000;

   // ****************************************
   // Timing
   // ****************************************
   localparam int PRESCALE_DEF = 2;

   // ****************************************
   // Pin bit positions of the serial port
   // ****************************************
   localparam int PB_RX  = 0;
   localparam int PB_TX  = 1;
   localparam int PB_CLK = 2;

   typedef enum logic [2:0] {
      MODE_EVENT   = 3'h0,
      MODE_MEASURE = 3'h1,
      MODE_WDOG    = 3'h2,
      MODE_TIMER   = 3'h3,
      MODE_PWM     = 3'h4
   } stpm_mode_t;

   typedef struct packed {
      logic out;
      logic oe;
   } stpm_pin_t;

endpackage : stpm_pkg

// file: src/stpm_pin_cell.sv
`timescale 1ns/1ps
module stpm_pin_cell (
   input  wire logic              i_clock,
   input  wire logic              i_rst,
   input  wire logic              i_func_sel,
   input  wire logic              i_gp_dir,
   input  wire logic              i_gp_out,
   input  wire logic              i_func_out,
   input  wire logic              i_func_oe,
   output stpm_pkg::stpm_pin_t    o_drive
);
   import stpm_pkg::*;

   stpm_pin_t drive_d;

   always_comb begin
      if (i_func_sel) begin
         drive_d.out = i_func_out;
         drive_d.oe  = i_func_oe;
      end else begin
         drive_d.out = i_gp_out;
         drive_d.oe  = i_gp_dir;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_drive <= '0;
      end else begin
         o_drive <= drive_d;
      end
   end

endmodule : stpm_pin_cell

// file: src/stpm_timer.sv
`timescale 1ns/1ps
module stpm_timer #(
   parameter int CNT_W = 24
) (
   input  wire logic                i_clock,
   input  wire logic                i_rst,
   input  wire logic                i_enable,
   input  stpm_pkg::stpm_mode_t     i_mode,
   input  wire logic                i_ext_sel,
   input  wire logic                i_tick,
   input  wire logic                i_pin,
   input  wire logic [CNT_W-1:0]    i_compare,
   input  wire logic                i_clear_done,
   output logic      [CNT_W-1:0]    o_count,
   output logic                     o_done,
   output logic                     o_pin_out
);
   import stpm_pkg::*;

   logic [CNT_W-1:0] count_d;
   logic             done_d;
   logic             pin_out_d;
   logic             pin_prev_q;
   logic             rise;
   logic             fall;
   logic             step;
   logic             term;
   logic [CNT_W-1:0] count_inc;

   assign rise      = i_pin & ~pin_prev_q;
   assign fall      = ~i_pin & pin_prev_q;
   assign count_inc = o_count + {{(CNT_W-1){1'b0}}, 1'b1};
   // Event mode always counts rising pin edges
   assign step = (i_ext_sel || i_mode == MODE_EVENT) ? rise : i_tick;
   // A compare value of zero never expires
   assign term = step && (i_compare != '0) && (count_inc == i_compare);

   always_comb begin
      count_d   = o_count;
      done_d    = o_done & ~i_clear_done;
      pin_out_d = o_pin_out;
      if (!i_enable) begin
         count_d   = '0;
         pin_out_d = 1'b0;
      end else begin
         unique case (i_mode)
            MODE_MEASURE: begin
               if (rise) begin
                  count_d = '0;
               end else if (i_pin && i_tick) begin
                  count_d = count_inc;
               end
               if (fall) begin
                  done_d = 1'b1;
               end
            end
            default: begin
               if (term) begin
                  count_d = '0;
                  done_d  = 1'b1;
               end else if (step) begin
                  count_d = count_inc;
               end
               if (i_mode == MODE_TIMER && term) begin
                  pin_out_d = ~o_pin_out;
               end
               if (i_mode == MODE_WDOG && term) begin
                  pin_out_d = 1'b1;
               end
               if (i_mode == MODE_PWM) begin
                  pin_out_d = (count_d < (i_compare >> 1));
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_count    <= '0;
         o_done     <= 1'b0;
         o_pin_out  <= 1'b0;
         pin_prev_q <= 1'b0;
      end else begin
         o_count    <= count_d;
         o_done     <= done_d;
         o_pin_out  <= pin_out_d;
         pin_prev_q <= i_pin;
      end
   end

endmodule : stpm_timer

// file: bench/stpm_chk.sv
`timescale 1ns/1ps
module stpm_chk (
   input wire logic        i_clock,
   input wire logic        i_rst,
   input wire logic [7:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0]  i_avs_byteenable,
   input wire logic        o_avs_waitrequest,
   input wire logic [2:0]  i_port_pin_in,
   input wire logic [2:0]  o_port_pin_out,
   input wire logic [2:0]  o_port_pin_oe,
   input wire logic        i_serial_tx,
   input wire logic        i_serial_clk_out,
   input wire logic        i_serial_clk_oe,
   input wire logic        o_serial_rx,
   input wire logic        o_serial_clk_in,
   input wire logic [2:0]  o_timer_pin_out,
   input wire logic [2:0]  o_timer_pin_oe,
   input wire logic [2:0]  o_timer_irq
);
   import stpm_pkg::*;
   // ********
   // Shadow registers
   // ********
   logic [2:0] ctl_q, dir_q, dat_q, p_oe, p_drv, t_oe, t_gm, t_gd, t_ie;
   logic [8:0] tc_q [3];
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         ctl_q <= 3'h0;
         dir_q <= 3'h0;
         dat_q <= 3'h0;
         tc_q  <= '{default: 9'h000};
      end else if (i_avs_write && !o_avs_waitrequest) begin
         if (i_avs_byteenable[0]) begin
            if (i_avs_address == OFS_PORT_CTRL) ctl_q <= i_avs_writedata[2:0];
            if (i_avs_address == OFS_PORT_DIR) dir_q <= i_avs_writedata[2:0];
            if (i_avs_address == OFS_PORT_DATA) dat_q <= i_avs_writedata[2:0];
         end
         for (int k = 0; k < 3; k++) begin
            if (i_avs_address == OFS_TMR_CTRL + OFS_TMR_STEP * 8'(k)) begin
               if (i_avs_byteenable[0]) tc_q[k][7:0] <= i_avs_writedata[7:0];
               if (i_avs_byteenable[1]) tc_q[k][8] <= i_avs_writedata[8];
            end
         end
      end
   end
   // Expected pin drive
   always_comb begin
      p_oe[0] = ctl_q[0] ? 1'h0 : dir_q[0];
      p_oe[1] = ctl_q[1] ? 1'h1 : dir_q[1];
      p_oe[2] = ctl_q[2] ? i_serial_clk_oe : dir_q[2];
      p_drv[0] = dat_q[0] & p_oe[0];
      p_drv[1] = (ctl_q[1] ? i_serial_tx : dat_q[1]) & p_oe[1];
      p_drv[2] = (ctl_q[2] ? i_serial_clk_out : dat_q[2]) & p_oe[2];
      for (int k = 0; k < 3; k++) begin
         t_oe[k] = tc_q[k][TC_FUNC] ? (tc_q[k][4:2] > 3'h1) : tc_q[k][TC_GP_DIR];
         t_gm[k] = !tc_q[k][TC_FUNC] && tc_q[k][TC_GP_DIR];
         t_gd[k] = t_gm[k] & tc_q[k][TC_GP_OUT];
         t_ie[k] = tc_q[k][TC_IRQ_EN];
      end
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   rx_pin_dir_a: assert property (o_port_pin_oe[0] == $past(p_oe[0]))
      else $error("rx pin dir wrong");
   tx_pin_dir_a: assert property (o_port_pin_oe[1] == $past(p_oe[1]))
      else $error("tx pin dir wrong");
   clk_pin_dir_a: assert property (o_port_pin_oe[2] == $past(p_oe[2]))
      else $error("clock pin dir wrong");
   pin_drive_a: assert property ((o_port_pin_out & o_port_pin_oe) == $past(p_drv))
      else $error("port pin drive wrong");
   rx_route_a: assert property (o_serial_rx == ($past(ctl_q[0]) ? $past(i_port_pin_in[0]) : 1'h1))
      else $error("receive routing wrong");
   clk_route_a: assert property ($past(ctl_q[2]) |-> o_serial_clk_in == $past(i_port_pin_in[2]))
      else $error("clock input routing wrong");
   tmr_pin_dir_a: assert property (o_timer_pin_oe == $past(t_oe))
      else $error("timer pin dir wrong");
   tmr_gp_out_a: assert property ((o_timer_pin_out & $past(t_gm)) == $past(t_gd))
      else $error("timer gpio output wrong");
   irq_mask_a: assert property ((o_timer_irq & ~$past(t_ie)) == 3'h0)
      else $error("timer irq while masked");
   reset_pins_a: assert property ($fell(i_rst) |-> o_port_pin_oe == 3'h0 && o_timer_pin_oe == 3'h0 && o_serial_rx)
      else $error("reset pin state wrong");
   bus_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("bus answer timing wrong");
   cover property ($rose(o_timer_irq[0]));
   cover property (o_port_pin_oe[2] && $past(ctl_q[2]));
   cover property ($rose(o_serial_clk_in));
endmodule : stpm_chk

bind stpm_top stpm_chk u_chk (.*);

// file: bench/stpm_far.sv
`timescale 1ns/1ps
module stpm_far (
   input  wire logic       i_clock,
   input  wire logic [5:0] i_dev_out,
   input  wire logic [5:0] i_dev_oe,
   input  wire logic [5:0] i_ext_en,
   input  wire logic [5:0] i_ext_val,
   output logic      [5:0] o_level
);
   // ********
   // Pin wires as the outside world sees them
   // ********
   logic float_q = 1'h0;
   // No pull: an undriven pin toggles so no read passes by luck
   always @(posedge i_clock) float_q <= !float_q;
   always_comb begin
      for (int k = 0; k < 6; k++) begin
         o_level[k] = i_dev_oe[k] ? i_dev_out[k] : (i_ext_en[k] ? i_ext_val[k] : float_q);
      end
   end
endmodule : stpm_far

// file: bench/serial_timer_pin_mux_test.sv
`timescale 1ns/1ps
module serial_timer_pin_mux_test;
   import stpm_pkg::*;
   // ********
   // Stimulus and wiring
   // ********
   logic        i_clock, i_rst, avs_rd, avs_wr, tx, clk_out, clk_oe, waitreq, s_rx, s_clk_in;
   logic [7:0]  avs_addr;
   logic [31:0] avs_wdata, rdata;
   logic [2:0]  pin_out, pin_oe, t_out, t_oe, irq;
   logic [5:0]  ext_en, ext_val, level;
   int          num_errors, n_tests;
   stpm_top #(.PRESCALE(1)) dut (.i_clock(i_clock), .i_rst(i_rst),
      .i_avs_address(avs_addr), .i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_writedata(avs_wdata),
      .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
      .i_port_pin_in(level[2:0]), .o_port_pin_out(pin_out), .o_port_pin_oe(pin_oe),
      .i_serial_tx(tx), .i_serial_clk_out(clk_out), .i_serial_clk_oe(clk_oe),
      .o_serial_rx(s_rx), .o_serial_clk_in(s_clk_in), .i_timer_pin_in(level[5:3]),
      .o_timer_pin_out(t_out), .o_timer_pin_oe(t_oe), .o_timer_irq(irq));
   stpm_far far (.i_clock(i_clock), .i_dev_out({t_out, pin_out}), .i_dev_oe({t_oe, pin_oe}),
      .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(level));
   task automatic final_report();
      $display("Checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report
   task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_val
   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_clock);
      avs_addr <= a;
      avs_wdata <= d;
      avs_rd <= rd;
      avs_wr <= !rd;
      do begin
         @(posedge i_clock);
         n++;
      end while (waitreq !== 1'h0 && n < 50);
      q = rdata;
      avs_rd <= 1'h0;
      avs_wr <= 1'h0;
      if (n >= 50) begin
         num_errors++;
         final_report();
      end
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'h0, a, d, q);
   endtask : wr
   task automatic settle();
      repeat (3) @(negedge i_clock);
   endtask : settle
   task automatic t_reset();
      logic [31:0] q;
      @(negedge i_clock);
      chk_val("port_oe", 32'h0, 32'(pin_oe));
      chk_val("timer_oe", 32'h0, 32'(t_oe));
      bus(1'h1, OFS_PORT_CTRL, 32'h0, q);
      chk_val("port_ctrl", 32'h0, q);
      bus(1'h1, OFS_TMR_CTRL + 8'h08, 32'h0, q);
      chk_val("tmr2_ctrl", 32'h0, q & 32'h3FF);
      bus(1'h1, 8'hFC, 32'h0, q);
      chk_val("unmapped", 32'h0, q);
   endtask : t_reset
   task automatic t_gpio();
      logic [31:0] q;
      ext_en[1] <= 1'h1;
      wr(OFS_PORT_DIR, 32'h5);
      wr(OFS_PORT_DATA, 32'h3);
      settle();
      chk_val("gpio_oe", 32'h5, 32'(pin_oe));
      chk_val("gpio_out", 32'h1, 32'(pin_out & pin_oe));
      bus(1'h1, OFS_PORT_DATA, 32'h0, q);
      chk_val("pin_lvl", 32'h1, q & 32'h7);
   endtask : t_gpio
   task automatic t_func();
      ext_en[0] <= 1'h1;
      ext_en[2] <= 1'h1;
      ext_val[2] <= 1'h1;
      tx <= 1'h1;
      wr(OFS_PORT_DIR, 32'h7);
      wr(OFS_PORT_CTRL, 32'h7);
      settle();
      chk_val("func_oe", 32'h2, 32'(pin_oe));
      chk_val("tx_out", 32'h1, 32'(pin_out[1]));
      chk_val("rx_route", 32'h0, 32'(s_rx));
      chk_val("clk_in", 32'h1, 32'(s_clk_in));
      @(posedge i_clock);
      tx <= 1'h0;
      clk_oe <= 1'h1;
      clk_out <= 1'h1;
      ext_en[2] <= 1'h0;
      ext_val[0] <= 1'h1;
      settle();
      chk_val("clk_oe", 32'h6, 32'(pin_oe));
      chk_val("clk_tx_out", 32'h2, 32'(pin_out[2:1]));
      chk_val("rx_route1", 32'h1, 32'(s_rx));
      wr(OFS_PORT_CTRL, 32'h2);
      settle();
      chk_val("mixed_oe", 32'h7, 32'(pin_oe));
      chk_val("mixed_out", 32'h1, 32'(pin_out));
      chk_val("clk_in_gp", 32'h0, 32'(s_clk_in));
   endtask : t_func
   task automatic t_tmr_modes();
      logic [31:0] q;
      logic [7:0]  a;
      for (int k = 0; k < 3; k++) begin
         a = OFS_TMR_CTRL + OFS_TMR_STEP * 8'(k);
         for (int m = 0; m < 5; m++) begin
            wr(a, 32'h1 | (32'(m) << 2));
            settle();
            chk_val("tmr_fn_oe", 32'(m > 1), 32'(t_oe[k]));
         end
         wr(a, 32'h180);
         settle();
         chk_val("tmr_gp_pin", 32'h3, 32'({t_oe[k], t_out[k]}));
         bus(1'h1, a, 32'h0, q);
         chk_val("tmr_rb", 32'h180, q & 32'h3FF);
         wr(a, 32'h0);
      end
   endtask : t_tmr_modes
   task automatic t_tmr_irq();
      logic [31:0] q;
      int n;
      wr(OFS_TMR_CMP, 32'h4);
      wr(OFS_TMR_CTRL, 32'h4F);
      for (n = 0; n < 60 && irq[0] !== 1'h1; n++) @(negedge i_clock);
      chk_val("irq_set", 32'h1, 32'(irq[0]));
      chk_val("tmr_toggle", 32'h1, 32'(t_out[0]));
      wr(OFS_TMR_CTRL, 32'h4D);
      bus(1'h1, OFS_TMR_CTRL, 32'h0, q);
      chk_val("done_bit", 32'h24D, q & 32'h3FF);
      wr(OFS_TMR_CTRL, 32'h0D);
      settle();
      chk_val("irq_mask", 32'h0, 32'(irq[0]));
      wr(OFS_TMR_CTRL, 32'h24D);
      settle();
      chk_val("irq_clr", 32'h0, 32'(irq[0]));
   endtask : t_tmr_irq
   task automatic t_tmr_ext();
      logic [31:0] q, q1;
      ext_en[4] <= 1'h1;
      wr(OFS_TMR_CMP + 8'h04, 32'h64);
      wr(OFS_TMR_CTRL + 8'h04, 32'h3);
      repeat (5) begin
         ext_val[4] <= 1'h1;
         repeat (3) @(posedge i_clock);
         ext_val[4] <= 1'h0;
         repeat (3) @(posedge i_clock);
      end
      bus(1'h1, OFS_TMR_CNT + 8'h04, 32'h0, q);
      chk_val("ext_count", 32'h5, q);
      wr(OFS_TMR_CTRL + 8'h08, 32'hF);
      bus(1'h1, OFS_TMR_CNT + 8'h08, 32'h0, q1);
      bus(1'h1, OFS_TMR_CNT + 8'h08, 32'h0, q);
      chk_val("int_count", 32'h1, 32'(q > q1));
   endtask : t_tmr_ext
   initial begin
      i_clock = 1'h0;
      forever #10 i_clock = ~i_clock;
   end
   initial begin
      {i_rst, avs_rd, avs_wr, tx, clk_out, clk_oe} = 6'h20;
      {avs_addr, avs_wdata, ext_en, ext_val} = '0;
      num_errors = 0;
      n_tests = 0;
      repeat (10) @(posedge i_clock);
      i_rst <= 1'h0;
      @(posedge i_clock);
      t_reset();
      t_gpio();
      t_func();
      t_tmr_modes();
      t_tmr_irq();
      t_tmr_ext();
      final_report();
   end
endmodule : serial_timer_pin_mux_test
